// >>> core/ccs_shadow_bank.sv
// Shadow copies of the core context registers with their register port.
//
// How it works
// (RULE1) Timeout flag set on power-up, watchdog clear, sleep
// (RULE2) Timeout flag cleared by watchdog time-out
// (RULE3) Power-down flag: sleep clears, power-up/clear sets
// (RULE4) Zero flag follows zero result of operation
// (RULE5) Digit carry from bit three on add/sub
// (RULE6) Carry from top bit on add/sub
// (RULE7) Subtract carries mean no borrow when set
// (RULE8) Subtract adds two's complement of second operand
// (RULE9) Rotates load carry with bit shifted out
// (RULE10) Power-on reset leaves contents arbitrary; others untouched; here every RST_B reset loads the zero POR values
// (RULE11) Bank select shadow holds six bits 5:0
// (RULE12) Program counter high shadow holds seven bits
// (RULE13) Two sixteen-bit indirect pointer shadows
// (RULE14) Each pointer reachable as high and low byte
// (RULE15) Timeout and power-down flags ignore writes
// (RULE16) Save on interrupt entry, restore on return
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ccs_shadow_bank (
	input  wire logic                          CLK_SYS,
	input  wire logic                          RST_B,
	// Register port
	input  wire logic [ccs_pkg::ADDR_W-1:0]    REG_ADDR,
	input  wire logic [ccs_pkg::DATA_W-1:0]    REG_WDATA,
	input  wire logic                          REG_WR,
	input  wire logic                          REG_RD,
	output logic      [ccs_pkg::DATA_W-1:0]    REG_RDATA,
	// Power management events from the core
	input  wire logic                          WDT_CLEAR_EXEC,
	input  wire logic                          SLEEP_EXEC,
	input  wire logic                          WDT_TIMEOUT,
	// Operation whose flags are tracked
	input  wire logic                          OP_VALID,
	input  wire logic [2:0]                    OP_KIND,
	input  wire logic [ccs_pkg::DATA_W-1:0]    OP_A,
	input  wire logic [ccs_pkg::DATA_W-1:0]    OP_B,
	output logic      [ccs_pkg::DATA_W-1:0]    OP_RESULT,
	output logic                               OP_DONE,
	// Context save and restore
	input  wire logic                          CTX_SAVE,
	input  wire logic                          CTX_RESTORE,
	input  wire logic [2:0]                    LIVE_FLAGS,
	input  wire logic [ccs_pkg::DATA_W-1:0]    LIVE_WORK,
	input  wire logic [ccs_pkg::BANK_W-1:0]    LIVE_BANK,
	input  wire logic [ccs_pkg::PCH_W-1:0]     LIVE_PCH,
	input  wire logic [ccs_pkg::PTR_W-1:0]     LIVE_PTR0,
	input  wire logic [ccs_pkg::PTR_W-1:0]     LIVE_PTR1,
	output logic      [ccs_pkg::FLAG_W-1:0]    SHD_FLAGS,
	output logic      [ccs_pkg::DATA_W-1:0]    SHD_WORK,
	output logic      [ccs_pkg::BANK_W-1:0]    SHD_BANK,
	output logic      [ccs_pkg::PCH_W-1:0]     SHD_PCH,
	output logic      [ccs_pkg::PTR_W-1:0]     SHD_PTR0,
	output logic      [ccs_pkg::PTR_W-1:0]     SHD_PTR1,
	output logic                               RESTORE_STB
);

	// -------------------------------------------------------------
	// Reset release
	// -------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;

	// Assert at once, release two edges later to avoid recovery races
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_n = rst_sync_reg;

	// -------------------------------------------------------------
	// Shadow storage
	// -------------------------------------------------------------
	logic                         to_reg;
	logic                         pd_reg;
	logic                         z_reg;
	logic                         dc_reg;
	logic                         c_reg;
	logic [ccs_pkg::DATA_W-1:0]   work_reg;
	logic [ccs_pkg::BANK_W-1:0]   bank_reg;
	logic [ccs_pkg::PCH_W-1:0]    pch_reg;
	logic [ccs_pkg::PTR_W-1:0]    ptr_reg [2];
	logic [ccs_pkg::DATA_W-1:0]   rdata_next;

	// -------------------------------------------------------------
	// Address decode
	// -------------------------------------------------------------
	logic wr_flags;
	logic wr_work;
	logic wr_bank;
	logic wr_pch;
	logic [1:0] wr_ptr_lo;
	logic [1:0] wr_ptr_hi;

	// One strobe per byte; pointers decode to their two bytes
	assign wr_flags     = REG_WR && (REG_ADDR == ccs_pkg::OFS_FLAGS);
	assign wr_work      = REG_WR && (REG_ADDR == ccs_pkg::OFS_WORK);
	assign wr_bank      = REG_WR && (REG_ADDR == ccs_pkg::OFS_BANK);
	assign wr_pch       = REG_WR && (REG_ADDR == ccs_pkg::OFS_PCH);
	assign wr_ptr_lo[0] = REG_WR && (REG_ADDR == ccs_pkg::OFS_PTR0_LO);
	assign wr_ptr_hi[0] = REG_WR && (REG_ADDR == ccs_pkg::OFS_PTR0_HI);
	assign wr_ptr_lo[1] = REG_WR && (REG_ADDR == ccs_pkg::OFS_PTR1_LO);
	assign wr_ptr_hi[1] = REG_WR && (REG_ADDR == ccs_pkg::OFS_PTR1_HI);

	// -------------------------------------------------------------
	// Flag computation
	// -------------------------------------------------------------
	ccs_alu_if alu ();
	logic op_go;

	// Unknown codes behave as no operation so no flag moves
	assign op_go       = OP_VALID && (OP_KIND != 3'h7);
	assign alu.op_kind = op_go ? ccs_pkg::ccs_op_t'(OP_KIND)
		: ccs_pkg::CCS_OP_NONE;
	assign alu.a        = OP_A;
	assign alu.b        = OP_B;
	assign alu.carry_in = c_reg; // RULE9

	ccs_flag_unit u_flag_unit (
		.alu (alu.unit)
	);

	// Result of each operation, registered for the core
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			OP_RESULT <= ccs_pkg::RDATA_POR;
			OP_DONE   <= 1'b0;
		end else begin
			OP_DONE <= op_go;
			if (op_go) begin
				OP_RESULT <= alu.result;
			end
		end
	end

	// -------------------------------------------------------------
	// Power management flags
	// -------------------------------------------------------------
	// Watchdog timeout flag: set events win over a same-cycle time-out,
	// so a clear or sleep in that cycle leaves the flag high.
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			to_reg <= ccs_pkg::TO_POR; // RULE1
		end else if (WDT_CLEAR_EXEC || SLEEP_EXEC) begin
			to_reg <= 1'b1; // RULE1
		end else if (WDT_TIMEOUT) begin
			to_reg <= 1'b0; // RULE2
		end
	end

	// Power-down flag: the watchdog clear is the set and wins over sleep
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			pd_reg <= ccs_pkg::PD_POR; // RULE3
		end else if (WDT_CLEAR_EXEC) begin
			pd_reg <= 1'b1; // RULE3
		end else if (SLEEP_EXEC) begin
			pd_reg <= 1'b0; // RULE3
		end
	end

	// -------------------------------------------------------------
	// Arithmetic flags
	// -------------------------------------------------------------
	// Save beats an operation, which beats a software write; the save
	// must capture the interrupted context exactly.
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			z_reg  <= ccs_pkg::ARITH_POR; // RULE10
			dc_reg <= ccs_pkg::ARITH_POR;
			c_reg  <= ccs_pkg::ARITH_POR;
		end else if (CTX_SAVE) begin
			z_reg  <= LIVE_FLAGS[ccs_pkg::FLAG_Z_BIT]; // RULE16
			dc_reg <= LIVE_FLAGS[ccs_pkg::FLAG_DC_BIT];
			c_reg  <= LIVE_FLAGS[ccs_pkg::FLAG_C_BIT];
		end else if (op_go) begin
			if (alu.upd_z) begin
				z_reg <= alu.z; // RULE4
			end
			if (alu.upd_dc) begin
				dc_reg <= alu.dc; // RULE5
			end
			if (alu.upd_c) begin
				c_reg <= alu.c; // RULE6 RULE9
			end
		end else if (wr_flags) begin
			// Only the three arithmetic bits take the write
			z_reg  <= REG_WDATA[ccs_pkg::FLAG_Z_BIT]; // RULE15
			dc_reg <= REG_WDATA[ccs_pkg::FLAG_DC_BIT];
			c_reg  <= REG_WDATA[ccs_pkg::FLAG_C_BIT];
		end
	end

	// -------------------------------------------------------------
	// Working, bank select and program counter high shadows
	// -------------------------------------------------------------
	// Contents are loaded with their POR values by every reset on RST_B
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			work_reg <= ccs_pkg::WORK_POR; // RULE10
		end else if (CTX_SAVE) begin
			work_reg <= LIVE_WORK; // RULE16
		end else if (wr_work) begin
			work_reg <= REG_WDATA;
		end
	end

	// Upper two write bits are dropped, they read back as zero
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			bank_reg <= ccs_pkg::BANK_POR; // RULE10
		end else if (CTX_SAVE) begin
			bank_reg <= LIVE_BANK; // RULE16
		end else if (wr_bank) begin
			bank_reg <= REG_WDATA[ccs_pkg::BANK_W-1:0]; // RULE11
		end
	end

	// Seven-bit latch, bit 7 of a write is dropped
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			pch_reg <= ccs_pkg::PCH_POR; // RULE10
		end else if (CTX_SAVE) begin
			pch_reg <= LIVE_PCH; // RULE16
		end else if (wr_pch) begin
			pch_reg <= REG_WDATA[ccs_pkg::PCH_W-1:0]; // RULE12
		end
	end

	// -------------------------------------------------------------
	// Indirect pointer shadows
	// -------------------------------------------------------------
	logic [ccs_pkg::PTR_W-1:0] live_ptr [2];

	assign live_ptr[0] = LIVE_PTR0;
	assign live_ptr[1] = LIVE_PTR1;

	// Bytes are written independently; no pairing latch is needed
	generate
		for (genvar i = 0; i < 2; i++) begin : g_ptr
			always_ff @(posedge CLK_SYS or negedge rst_n) begin
				if (!rst_n) begin
					ptr_reg[i] <= ccs_pkg::PTR_POR; // RULE10
				end else if (CTX_SAVE) begin
					ptr_reg[i] <= live_ptr[i]; // RULE13 RULE16
				end else begin
					if (wr_ptr_lo[i]) begin
						ptr_reg[i][7:0] <= REG_WDATA; // RULE14
					end
					if (wr_ptr_hi[i]) begin
						ptr_reg[i][15:8] <= REG_WDATA; // RULE14
					end
				end
			end
		end
	endgenerate

	// -------------------------------------------------------------
	// Read path
	// -------------------------------------------------------------
	// Unused bits and unmapped addresses read as zero
	always_comb begin
		rdata_next = '0;
		unique case (REG_ADDR)
			ccs_pkg::OFS_FLAGS: begin
				rdata_next[ccs_pkg::FLAG_TO_BIT] = to_reg;
				rdata_next[ccs_pkg::FLAG_PD_BIT] = pd_reg;
				rdata_next[ccs_pkg::FLAG_Z_BIT]  = z_reg;
				rdata_next[ccs_pkg::FLAG_DC_BIT] = dc_reg;
				rdata_next[ccs_pkg::FLAG_C_BIT]  = c_reg;
			end
			ccs_pkg::OFS_WORK: begin
				rdata_next = work_reg;
			end
			ccs_pkg::OFS_BANK: begin
				rdata_next = {2'b00, bank_reg}; // RULE11
			end
			ccs_pkg::OFS_PCH: begin
				rdata_next = {1'b0, pch_reg}; // RULE12
			end
			ccs_pkg::OFS_PTR0_LO: begin
				rdata_next = ptr_reg[0][7:0]; // RULE14
			end
			ccs_pkg::OFS_PTR0_HI: begin
				rdata_next = ptr_reg[0][15:8]; // RULE14
			end
			ccs_pkg::OFS_PTR1_LO: begin
				rdata_next = ptr_reg[1][7:0];
			end
			ccs_pkg::OFS_PTR1_HI: begin
				rdata_next = ptr_reg[1][15:8];
			end
			default: begin
				rdata_next = '0;
			end
		endcase
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			REG_RDATA <= ccs_pkg::RDATA_POR;
		end else if (REG_RD) begin
			REG_RDATA <= rdata_next;
		end else begin
			REG_RDATA <= ccs_pkg::RDATA_POR;
		end
	end

	// -------------------------------------------------------------
	// Restore path to the core
	// -------------------------------------------------------------
	// Shadow values are mirrored in flops so the core can reload them
	// on the cycle after the restore strobe.
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			SHD_FLAGS   <= '0;
			SHD_WORK    <= ccs_pkg::WORK_POR;
			SHD_BANK    <= ccs_pkg::BANK_POR;
			SHD_PCH     <= ccs_pkg::PCH_POR;
			SHD_PTR0    <= ccs_pkg::PTR_POR;
			SHD_PTR1    <= ccs_pkg::PTR_POR;
			RESTORE_STB <= 1'b0;
		end else begin
			RESTORE_STB <= CTX_RESTORE; // RULE16
			if (CTX_RESTORE) begin
				SHD_FLAGS <= {to_reg, pd_reg, z_reg, dc_reg, c_reg};
				SHD_WORK  <= work_reg; // RULE16
				SHD_BANK  <= bank_reg;
				SHD_PCH   <= pch_reg;
				SHD_PTR0  <= ptr_reg[0]; // RULE13
				SHD_PTR1  <= ptr_reg[1]; // RULE13
			end
		end
	end

endmodule : ccs_shadow_bank
`default_nettype wire

// >>> core/ccs_pkg.sv
// Constants, offsets and operation codes of the context shadow bank.
package ccs_pkg;

	// -------------------------------------------------------------
	// Widths
	// -------------------------------------------------------------
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int BANK_W = 6;
	localparam int PCH_W  = 7;
	localparam int PTR_W  = 16;
	localparam int FLAG_W = 5;

	// -------------------------------------------------------------
	// Register byte offsets
	// -------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_FLAGS   = 13'h1FE4;
	localparam logic [ADDR_W-1:0] OFS_WORK    = 13'h1FE5;
	localparam logic [ADDR_W-1:0] OFS_BANK    = 13'h1FE6;
	localparam logic [ADDR_W-1:0] OFS_PCH     = 13'h1FE7;
	localparam logic [ADDR_W-1:0] OFS_PTR0_LO = 13'h1FE8;
	localparam logic [ADDR_W-1:0] OFS_PTR0_HI = 13'h1FE9;
	localparam logic [ADDR_W-1:0] OFS_PTR1_LO = 13'h1FEA;
	localparam logic [ADDR_W-1:0] OFS_PTR1_HI = 13'h1FEB;

	// -------------------------------------------------------------
	// Field positions in the flags shadow
	// -------------------------------------------------------------
	localparam int FLAG_TO_BIT = 4;
	localparam int FLAG_PD_BIT = 3;
	localparam int FLAG_Z_BIT  = 2;
	localparam int FLAG_DC_BIT = 1;
	localparam int FLAG_C_BIT  = 0;

	// -------------------------------------------------------------
	// Values after power-on reset
	// -------------------------------------------------------------
	localparam logic              TO_POR    = 1'b1;
	localparam logic              PD_POR    = 1'b1;
	localparam logic              ARITH_POR = 1'b0;
	localparam logic [DATA_W-1:0] WORK_POR  = 8'h00;
	localparam logic [BANK_W-1:0] BANK_POR  = 6'h00;
	localparam logic [PCH_W-1:0]  PCH_POR   = 7'h00;
	localparam logic [PTR_W-1:0]  PTR_POR   = 16'h0000;
	localparam logic [DATA_W-1:0] RDATA_POR = 8'h00;

	// -------------------------------------------------------------
	// Operations whose flags the bank tracks
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		CCS_OP_ADD  = 3'h0,
		CCS_OP_SUB  = 3'h1,
		CCS_OP_AND  = 3'h2,
		CCS_OP_OR   = 3'h3,
		CCS_OP_XOR  = 3'h4,
		CCS_OP_ROTL = 3'h5,
		CCS_OP_ROTR = 3'h6,
		CCS_OP_NONE = 3'h7
	} ccs_op_t;

endpackage : ccs_pkg

// >>> core/ccs_alu_if.sv
// Link between the shadow bank and its flag computation unit.
`timescale 1ns/1ps
`default_nettype none
interface ccs_alu_if;
	ccs_pkg::ccs_op_t                  op_kind;
	logic [ccs_pkg::DATA_W-1:0]        a;
	logic [ccs_pkg::DATA_W-1:0]        b;
	logic                              carry_in;
	logic [ccs_pkg::DATA_W-1:0]        result;
	logic                              z;
	logic                              dc;
	logic                              c;
	logic                              upd_z;
	logic                              upd_dc;
	logic                              upd_c;

	modport bank (
		output op_kind, a, b, carry_in,
		input  result, z, dc, c, upd_z, upd_dc, upd_c
	);
	modport unit (
		input  op_kind, a, b, carry_in,
		output result, z, dc, c, upd_z, upd_dc, upd_c
	);
endinterface : ccs_alu_if
`default_nettype wire

// >>> core/ccs_flag_unit.sv
// Result and flag computation for add, subtract, logic and rotate.
`timescale 1ns/1ps
`default_nettype none
module ccs_flag_unit (
	ccs_alu_if.unit alu
);
	localparam int W = ccs_pkg::DATA_W;

	// -------------------------------------------------------------
	// Adder shared by add and subtract
	// -------------------------------------------------------------
	logic         is_sub;
	logic [W-1:0] b_eff;
	logic [W:0]   sum_full;
	logic [4:0]   sum_low;

	// Subtract reuses the adder with the inverted operand and a carry in
	assign is_sub   = (alu.op_kind == ccs_pkg::CCS_OP_SUB);
	assign b_eff    = is_sub ? ~alu.b : alu.b; // RULE8
	assign sum_full = {1'b0, alu.a} + {1'b0, b_eff}
		+ {{W{1'b0}}, is_sub}; // RULE8
	assign sum_low  = {1'b0, alu.a[3:0]} + {1'b0, b_eff[3:0]}
		+ {4'h0, is_sub};

	// -------------------------------------------------------------
	// Result and flag selection
	// -------------------------------------------------------------
	// Borrow flags fall out inverted because the adder carries out
	// exactly when no borrow happened; no extra inversion is needed.
	always_comb begin
		alu.result = '0;
		alu.dc     = 1'b0;
		alu.c      = 1'b0;
		alu.upd_z  = 1'b0;
		alu.upd_dc = 1'b0;
		alu.upd_c  = 1'b0;
		unique case (alu.op_kind)
			ccs_pkg::CCS_OP_ADD, ccs_pkg::CCS_OP_SUB: begin
				alu.result = sum_full[W-1:0];
				alu.dc     = sum_low[4]; // RULE5 RULE7
				alu.c      = sum_full[W]; // RULE6 RULE7
				alu.upd_z  = 1'b1;
				alu.upd_dc = 1'b1;
				alu.upd_c  = 1'b1;
			end
			ccs_pkg::CCS_OP_AND: begin
				alu.result = alu.a & alu.b;
				alu.upd_z  = 1'b1;
			end
			ccs_pkg::CCS_OP_OR: begin
				alu.result = alu.a | alu.b;
				alu.upd_z  = 1'b1;
			end
			ccs_pkg::CCS_OP_XOR: begin
				alu.result = alu.a ^ alu.b;
				alu.upd_z  = 1'b1;
			end
			ccs_pkg::CCS_OP_ROTL: begin
				alu.result = {alu.a[W-2:0], alu.carry_in};
				alu.c      = alu.a[W-1]; // RULE9
				alu.upd_c  = 1'b1;
			end
			ccs_pkg::CCS_OP_ROTR: begin
				alu.result = {alu.carry_in, alu.a[W-1:1]};
				alu.c      = alu.a[0]; // RULE9
				alu.upd_c  = 1'b1;
			end
			ccs_pkg::CCS_OP_NONE: begin
				alu.result = '0;
			end
		endcase
	end

	// Zero test on whatever result was selected
	assign alu.z = (alu.result == '0); // RULE4

endmodule : ccs_flag_unit
`default_nettype wire

// >>> test/ccs_shadow_bank_checker.sv
// Port-level assertions for the context shadow bank.
`timescale 1ns/1ps
`default_nettype none
module ccs_shadow_bank_checker (
	input wire logic        CLK_SYS,
	input wire logic        RST_B,
	input wire logic [12:0] REG_ADDR,
	input wire logic [7:0]  REG_WDATA,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [7:0]  REG_RDATA,
	input wire logic        WDT_CLEAR_EXEC,
	input wire logic        SLEEP_EXEC,
	input wire logic        WDT_TIMEOUT,
	input wire logic        OP_VALID,
	input wire logic [2:0]  OP_KIND,
	input wire logic [7:0]  OP_A,
	input wire logic [7:0]  OP_B,
	input wire logic [7:0]  OP_RESULT,
	input wire logic        OP_DONE,
	input wire logic        CTX_SAVE,
	input wire logic        CTX_RESTORE,
	input wire logic [7:0]  LIVE_WORK,
	input wire logic [7:0]  SHD_WORK,
	input wire logic        RESTORE_STB
);
	// ----------------------------------------------------------------
	// Shared qualifiers
	// ----------------------------------------------------------------
	// A save in the same cycle overrides the flags, so it is excluded
	wire logic rd_flg = REG_RD && REG_ADDR == ccs_pkg::OFS_FLAGS;
	wire logic pwr_ev = WDT_CLEAR_EXEC || SLEEP_EXEC || WDT_TIMEOUT;
	wire logic arith  = OP_VALID && !CTX_SAVE;

	default clocking dcb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	chk_clear_sets_both: assert property (
		WDT_CLEAR_EXEC ##1 rd_flg |=> REG_RDATA[4:3] == 2'b11)
		else $error("flags not set after watchdog clear");
	chk_timeout_clears: assert property (
		WDT_TIMEOUT && !WDT_CLEAR_EXEC && !SLEEP_EXEC ##1 rd_flg
		|=> !REG_RDATA[4]) else $error("timeout flag not cleared");
	chk_sleep_flags: assert property (
		SLEEP_EXEC && !WDT_CLEAR_EXEC ##1 rd_flg
		|=> REG_RDATA[4:3] == 2'b10) else $error("sleep flags wrong");
	chk_zero_flag: assert property (
		arith && OP_KIND < 3'h5 ##1 rd_flg
		|=> REG_RDATA[2] == ($past(OP_RESULT) == 8'h00))
		else $error("zero flag does not match result");
	chk_sub_no_borrow: assert property (
		arith && OP_KIND == ccs_pkg::CCS_OP_SUB ##1 rd_flg
		|=> REG_RDATA[0] == ($past(OP_A, 2) >= $past(OP_B, 2)))
		else $error("subtract carry polarity wrong");
	chk_sub_result: assert property (
		OP_VALID && OP_KIND == ccs_pkg::CCS_OP_SUB
		|=> OP_RESULT == $past(OP_A) - $past(OP_B))
		else $error("subtract result wrong");
	chk_rotl_carry: assert property (
		arith && OP_KIND == ccs_pkg::CCS_OP_ROTL ##1 rd_flg
		|=> REG_RDATA[0] == $past(OP_A[7], 2)
		&& $past(OP_RESULT[7:1]) == $past(OP_A[6:0], 2))
		else $error("rotate left carry wrong");
	chk_rotr_carry: assert property (
		arith && OP_KIND == ccs_pkg::CCS_OP_ROTR ##1 rd_flg
		|=> REG_RDATA[0] == $past(OP_A[0], 2)
		&& $past(OP_RESULT[6:0]) == $past(OP_A[7:1], 2))
		else $error("rotate right carry wrong");
	chk_flags_ro_bits: assert property (
		rd_flg && !pwr_ev ##1 REG_WR && REG_ADDR == ccs_pkg::OFS_FLAGS
		&& !pwr_ev ##1 rd_flg
		|=> REG_RDATA[4:3] == $past(REG_RDATA[4:3], 2))
		else $error("read-only flags changed by a write");
	chk_bank_width: assert property (
		REG_WR && REG_ADDR == ccs_pkg::OFS_BANK && !CTX_SAVE
		##1 REG_RD && REG_ADDR == ccs_pkg::OFS_BANK
		|=> REG_RDATA == {2'b00, $past(REG_WDATA[5:0], 2)})
		else $error("bank shadow width wrong");
	chk_pch_width: assert property (
		REG_WR && REG_ADDR == ccs_pkg::OFS_PCH && !CTX_SAVE
		##1 REG_RD && REG_ADDR == ccs_pkg::OFS_PCH
		|=> REG_RDATA == {1'b0, $past(REG_WDATA[6:0], 2)})
		else $error("pc high shadow width wrong");
	chk_save_restore: assert property (
		CTX_SAVE ##1 CTX_RESTORE && !CTX_SAVE
		|=> RESTORE_STB && SHD_WORK == $past(LIVE_WORK, 2))
		else $error("restored value differs from saved");

	// Main scenarios reached
	cov_op_done: cover property (OP_DONE);
	cov_restore: cover property (RESTORE_STB);
	cov_timeout: cover property (rd_flg ##1 REG_RDATA[4:3] == 2'b00);
endmodule : ccs_shadow_bank_checker

bind ccs_shadow_bank ccs_shadow_bank_checker chk_u (.CLK_SYS, .RST_B,
	.REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .WDT_CLEAR_EXEC,
	.SLEEP_EXEC, .WDT_TIMEOUT, .OP_VALID, .OP_KIND, .OP_A, .OP_B,
	.OP_RESULT, .OP_DONE, .CTX_SAVE, .CTX_RESTORE, .LIVE_WORK, .SHD_WORK,
	.RESTORE_STB);
`default_nettype wire

// >>> test/ccs_shadow_bank_tb.sv
// Self-checking testbench for the context shadow bank.
`timescale 1ns/1ps
`default_nettype none
module ccs_shadow_bank_tb;
	localparam logic [12:0] FL = ccs_pkg::OFS_FLAGS;
	logic        CLK_SYS, RST_B, REG_WR, REG_RD, OP_VALID, OP_DONE;
	logic        WDT_CLEAR_EXEC, SLEEP_EXEC, WDT_TIMEOUT;
	logic        CTX_SAVE, CTX_RESTORE, RESTORE_STB;
	logic [12:0] REG_ADDR;
	logic [7:0]  REG_WDATA, REG_RDATA, OP_A, OP_B, OP_RESULT;
	logic [7:0]  LIVE_WORK, SHD_WORK;
	logic [2:0]  OP_KIND, LIVE_FLAGS;
	logic [4:0]  SHD_FLAGS;
	logic [5:0]  LIVE_BANK, SHD_BANK;
	logic [6:0]  LIVE_PCH, SHD_PCH;
	logic [15:0] LIVE_PTR0, LIVE_PTR1, SHD_PTR0, SHD_PTR1;
	int          fails, checks;

	ccs_shadow_bank dut_u (.CLK_SYS, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WR,
		.REG_RD, .REG_RDATA, .WDT_CLEAR_EXEC, .SLEEP_EXEC, .WDT_TIMEOUT,
		.OP_VALID, .OP_KIND, .OP_A, .OP_B, .OP_RESULT, .OP_DONE, .CTX_SAVE,
		.CTX_RESTORE, .LIVE_FLAGS, .LIVE_WORK, .LIVE_BANK, .LIVE_PCH,
		.LIVE_PTR0, .LIVE_PTR1, .SHD_FLAGS, .SHD_WORK, .SHD_BANK, .SHD_PCH,
		.SHD_PTR0, .SHD_PTR1, .RESTORE_STB);

	// ----------------------------------------------------------------
	// Clock, verdict and tasks
	// ----------------------------------------------------------------
	initial begin
		CLK_SYS = 1'b0;
		forever #4 CLK_SYS = ~CLK_SYS;
	end

	task automatic conclude;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One register port cycle; the strobes stay until the next call
	task automatic bus(input logic w, input logic r, input logic [12:0] a,
		input logic [7:0] d);
		@(posedge CLK_SYS);
		REG_WR <= w;
		REG_RD <= r;
		REG_ADDR <= a;
		REG_WDATA <= d;
	endtask : bus

	task automatic rd(input logic [12:0] a, input logic [7:0] m,
		input logic [7:0] e);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		#1;
		chk({8'h00, REG_RDATA & m}, {8'h00, e});
	endtask : rd

	// Write followed at once by a read of the same byte
	task automatic wrd(input logic [12:0] a, input logic [7:0] d,
		input logic [7:0] e);
		bus(1'b1, 1'b0, a, d);
		rd(a, 8'hFF, e);
	endtask : wrd

	// Events as {clear, sleep, timeout}, flags read in the next cycle
	task automatic pwr(input logic [2:0] ev, input logic [7:0] e);
		@(posedge CLK_SYS);
		{WDT_CLEAR_EXEC, SLEEP_EXEC, WDT_TIMEOUT} <= ev;
		bus(1'b0, 1'b1, FL, 8'h00);
		{WDT_CLEAR_EXEC, SLEEP_EXEC, WDT_TIMEOUT} <= 3'h0;
		bus(1'b0, 1'b0, FL, 8'h00);
		#1;
		chk({8'h00, REG_RDATA & 8'h18}, {8'h00, e});
	endtask : pwr

	// Preset {Z,DC,C}, run one operation, then read the flags back
	task automatic op(input logic [2:0] k, input logic [7:0] a,
		input logic [7:0] b, input logic [2:0] pre, input logic [7:0] res,
		input logic [2:0] flg);
		bus(1'b1, 1'b0, FL, {5'h00, pre});
		bus(1'b0, 1'b0, FL, 8'h00);
		OP_VALID <= 1'b1;
		OP_KIND <= k;
		OP_A <= a;
		OP_B <= b;
		bus(1'b0, 1'b1, FL, 8'h00);
		OP_VALID <= 1'b0;
		#1;
		chk({15'h0000, OP_DONE}, 16'h0001);
		chk({8'h00, OP_RESULT}, {8'h00, res});
		bus(1'b0, 1'b0, FL, 8'h00);
		#1;
		chk({8'h00, REG_RDATA & 8'h07}, {13'h0000, flg});
	endtask : op

	// Hang guard, well beyond the roughly 150 cycles of the tests
	initial begin
		repeat (5000) @(posedge CLK_SYS);
		fails++;
		conclude();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{RST_B, REG_WR, REG_RD, OP_VALID, CTX_SAVE, CTX_RESTORE} = 6'h00;
		{WDT_CLEAR_EXEC, SLEEP_EXEC, WDT_TIMEOUT, OP_KIND} = 6'h07;
		{REG_ADDR, REG_WDATA, OP_A, OP_B} = 37'h00_0000_0000;
		{LIVE_FLAGS, LIVE_WORK, LIVE_BANK, LIVE_PCH} = 24'h00_0000;
		{LIVE_PTR0, LIVE_PTR1} = 32'h0000_0000;
		fails = 0;
		checks = 0;
		repeat (20) @(posedge CLK_SYS);
		RST_B <= 1'b1;
		repeat (2) @(posedge CLK_SYS);
		rd(FL, 8'hF8, 8'h18);
		pwr(3'b001, 8'h08);
		pwr(3'b010, 8'h10);
		pwr(3'b001, 8'h00);
		pwr(3'b011, 8'h10);
		pwr(3'b100, 8'h18);
		wrd(FL, 8'hFF, 8'h1F);
		wrd(FL, 8'h00, 8'h18);
		bus(1'b0, 1'b1, FL, 8'h00);
		bus(1'b1, 1'b0, FL, 8'hE7);
		#1 chk({8'h00, REG_RDATA}, 16'h0018);
		rd(FL, 8'hFF, 8'h1F);
		wrd(ccs_pkg::OFS_WORK, 8'hA5, 8'hA5);
		wrd(ccs_pkg::OFS_BANK, 8'hFF, 8'h3F);
		wrd(ccs_pkg::OFS_BANK, 8'hC0, 8'h00);
		wrd(ccs_pkg::OFS_PCH, 8'hFF, 8'h7F);
		wrd(ccs_pkg::OFS_PCH, 8'h80, 8'h00);
		wrd(ccs_pkg::OFS_PTR0_LO, 8'h11, 8'h11);
		wrd(ccs_pkg::OFS_PTR0_HI, 8'h22, 8'h22);
		wrd(ccs_pkg::OFS_PTR1_LO, 8'h33, 8'h33);
		wrd(ccs_pkg::OFS_PTR1_HI, 8'h44, 8'h44);
		rd(ccs_pkg::OFS_PTR0_LO, 8'hFF, 8'h11);
		wrd(13'h1FE3, 8'hFF, 8'h00);
		wrd(13'h1FEC, 8'hFF, 8'h00);
		op(3'h0, 8'h05, 8'h05, 3'h0, 8'h0A, 3'h0);
		op(3'h0, 8'h0F, 8'h01, 3'h0, 8'h10, 3'h2);
		op(3'h0, 8'hF0, 8'h10, 3'h7, 8'h00, 3'h5);
		op(3'h0, 8'hFF, 8'h01, 3'h0, 8'h00, 3'h7);
		op(3'h1, 8'h05, 8'h05, 3'h0, 8'h00, 3'h7);
		op(3'h1, 8'h03, 8'h05, 3'h7, 8'hFE, 3'h0);
		op(3'h1, 8'h10, 8'h01, 3'h0, 8'h0F, 3'h1);
		op(3'h2, 8'hF0, 8'h0F, 3'h3, 8'h00, 3'h7);
		op(3'h3, 8'h12, 8'h01, 3'h7, 8'h13, 3'h3);
		op(3'h4, 8'hAA, 8'hAA, 3'h0, 8'h00, 3'h4);
		op(3'h5, 8'h80, 8'h00, 3'h0, 8'h00, 3'h1);
		op(3'h5, 8'h01, 8'h00, 3'h1, 8'h03, 3'h0);
		op(3'h6, 8'h01, 8'h00, 3'h0, 8'h00, 3'h1);
		op(3'h6, 8'h02, 8'h00, 3'h1, 8'h81, 3'h0);
		bus(1'b0, 1'b0, FL, 8'h00);
		OP_VALID <= 1'b1;
		OP_KIND <= 3'h7;
		bus(1'b0, 1'b0, FL, 8'h00);
		OP_VALID <= 1'b0;
		#1 chk({7'h00, OP_DONE, OP_RESULT}, 16'h0081);
		// Save with a colliding write, then restore straight after
		bus(1'b1, 1'b0, ccs_pkg::OFS_WORK, 8'h11);
		{LIVE_FLAGS, LIVE_WORK, LIVE_BANK, LIVE_PCH} <= 24'hB5_5555;
		{LIVE_PTR0, LIVE_PTR1} <= 32'h1234_BEEF;
		CTX_SAVE <= 1'b1;
		bus(1'b0, 1'b0, FL, 8'h00);
		CTX_SAVE <= 1'b0;
		CTX_RESTORE <= 1'b1;
		bus(1'b0, 1'b0, FL, 8'h00);
		CTX_RESTORE <= 1'b0;
		#1 chk({RESTORE_STB, SHD_FLAGS, SHD_BANK, 4'h0}, 16'hF6A0);
		chk({SHD_WORK, 1'b0, SHD_PCH}, 16'hAA55);
		chk(SHD_PTR0, 16'h1234);
		chk(SHD_PTR1, 16'hBEEF);
		rd(ccs_pkg::OFS_WORK, 8'hFF, 8'hAA);
		chk({15'h0000, RESTORE_STB}, 16'h0000);
		rd(ccs_pkg::OFS_PTR1_HI, 8'hFF, 8'hBE);
		rd(FL, 8'hFF, 8'h1D);
		conclude();
	end
endmodule : ccs_shadow_bank_tb
`default_nettype wire
